// ### common/core_pkg.sv
// Shared constants, encodings and carrier types of the 8-bit core datapath.
`default_nettype none
package core_pkg;
  localparam int INSTR_W        = 12;
  localparam int DATA_W         = 8;
  localparam int FILE_W         = 5;
  localparam int PROG_DEPTH_DEF = 1024;
  localparam int DATA_DEPTH_DEF = 72;
  localparam int INSTR_COUNT    = 33;
  // Special function register addresses in the data space.
  localparam logic [DATA_W-1:0] ADDR_INDIRECT = 8'h00;
  localparam logic [DATA_W-1:0] ADDR_PC       = 8'h02;
  localparam logic [DATA_W-1:0] ADDR_STATUS   = 8'h03;
  localparam logic [DATA_W-1:0] ADDR_FSR      = 8'h04;
  localparam logic [DATA_W-1:0] ADDR_EXT_BASE = 8'h05;
  // Status register field positions.
  localparam int STATUS_C  = 0;
  localparam int STATUS_NIBBLE = 1;
  localparam int STATUS_Z  = 2;
  // Reset values.
  localparam logic [DATA_W-1:0]  W_RESET      = 8'h00;
  localparam logic [DATA_W-1:0]  STATUS_RESET = 8'h00;
  localparam logic [DATA_W-1:0]  FSR_RESET    = 8'h00;
  localparam logic [INSTR_W-1:0] IR_RESET     = 12'h000;
  // Timing: one clock edge is one instruction cycle; branches cost one refill cycle more.
  localparam int CLK_PERIOD_NS  = 100;
  localparam int CYCLE_NS_FAST  = 200;
  localparam int CYCLE_NS_SLOW  = 1000;
  localparam int EXEC_CYCLES    = (CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BRANCH_CYCLES  = 2 * EXEC_CYCLES;

  typedef enum logic [3:0] {
    ALU_PASS_A,
    ALU_PASS_B,
    ALU_ADD,
    ALU_SUB,
    ALU_AND,
    ALU_OR,
    ALU_XOR,
    ALU_COM,
    ALU_INC,
    ALU_DEC,
    ALU_RRF,
    ALU_RLF,
    ALU_SWAP,
    ALU_CLR
  } alu_op_e;

  typedef struct packed {
    alu_op_e           op;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic              cin;
  } alu_in_s;

  typedef struct packed {
    logic [DATA_W-1:0] res;
    logic              c;
    logic              nibble_carry_flag;
    logic              z;
  } alu_out_s;
endpackage
`default_nettype wire

// ### hw/core_alu.sv
// Combinational 8-bit ALU with carry, nibble carry and zero outputs.
`timescale 1ns/1ps
`default_nettype none
module core_alu (
  input  wire core_pkg::alu_in_s  alu_in,
  output var  core_pkg::alu_out_s alu_out
);
  import core_pkg::*;

  logic [DATA_W:0] sum;
  logic [4:0]      low;

  always_comb
  begin
    sum         = '0;
    low         = '0;
    alu_out.res = '0;
    alu_out.c   = 1'b0;
    alu_out.nibble_carry_flag = 1'b0;
    unique case (alu_in.op)
      ALU_PASS_A: alu_out.res = alu_in.a;
      ALU_PASS_B: alu_out.res = alu_in.b;
      ALU_ADD:
      begin
        sum = {1'b0, alu_in.b} + {1'b0, alu_in.a};
        low = {1'b0, alu_in.b[3:0]} + {1'b0, alu_in.a[3:0]};
        alu_out.res = sum[DATA_W-1:0];
        alu_out.c   = sum[DATA_W];
        alu_out.nibble_carry_flag = low[4];
      end
      ALU_SUB:
      begin
        sum = {1'b0, alu_in.b} + {1'b0, ~alu_in.a} + 9'h001;
        low = {1'b0, alu_in.b[3:0]} + {1'b0, ~alu_in.a[3:0]} + 5'h01;
        alu_out.res = sum[DATA_W-1:0];
        alu_out.c   = sum[DATA_W];
        alu_out.nibble_carry_flag = low[4];
      end
      ALU_AND:  alu_out.res = alu_in.a & alu_in.b;
      ALU_OR:   alu_out.res = alu_in.a | alu_in.b;
      ALU_XOR:  alu_out.res = alu_in.a ^ alu_in.b;
      ALU_COM:  alu_out.res = ~alu_in.b;
      ALU_INC:  alu_out.res = alu_in.b + 8'h01;
      ALU_DEC:  alu_out.res = alu_in.b - 8'h01;
      ALU_RRF:
      begin
        alu_out.res = {alu_in.cin, alu_in.b[DATA_W-1:1]};
        alu_out.c   = alu_in.b[0];
      end
      ALU_RLF:
      begin
        alu_out.res = {alu_in.b[DATA_W-2:0], alu_in.cin};
        alu_out.c   = alu_in.b[DATA_W-1];
      end
      ALU_SWAP: alu_out.res = {alu_in.b[3:0], alu_in.b[7:4]};
      ALU_CLR:  alu_out.res = '0;
      default:  alu_out.res = '0;
    endcase
    alu_out.z = (alu_out.res == '0);
  end
endmodule
`default_nettype wire

// ### hw/eight_bit_risc_core_datapath.sv
// Two-stage 8-bit core: 12-bit fetch, decode, accumulator ALU and special registers.
//
// Overview of operation
// - Program fetch and data access use separate ports, active in the same cycle.
// - Each instruction is one 12-bit word, fetched whole every cycle.
// - Next instruction is fetched while the current one executes.
// - Non-branch instructions finish in one instruction cycle, except a skip whose test is met, which takes two.
// - Instructions that change program flow take two instruction cycles.
// - Program depth 512 or 1024 words; data depth 25, 41 or 72 bytes.
// - Special registers, program counter included, sit in data space, direct or indirect.
// - Any operation works on any register indirectly; direct addressing reaches only addresses below 32.
// - 8-bit ALU adds, subtracts, shifts and does logic on accumulator and file.
// - Arithmetic treats operands as two's complement values.
// - Two-operand uses accumulator plus file or literal; one-operand reads only the file, writing to either.
// - The 8-bit accumulator has no data address.
// - ALU updates carry, nibble carry and zero flags per instruction.
// - In subtraction carry and nibble carry mean no borrow.
`timescale 1ns/1ps
`default_nettype none
module eight_bit_risc_core_datapath #(
  parameter int PROG_DEPTH = core_pkg::PROG_DEPTH_DEF,
  parameter int DATA_DEPTH = core_pkg::DATA_DEPTH_DEF
) (
  input  wire logic                              sys_clk,
  input  wire logic                              sys_rst,
  output logic [$clog2(PROG_DEPTH)-1:0]          prog_addr,
  input  wire logic [core_pkg::INSTR_W-1:0]      prog_data,
  output logic [core_pkg::DATA_W-1:0]            data_addr,
  output logic [core_pkg::DATA_W-1:0]            data_wdata,
  output logic                                   data_we,
  input  wire logic [core_pkg::DATA_W-1:0]       data_rdata,
  output logic [core_pkg::DATA_W-1:0]            acc_value,
  output logic [core_pkg::DATA_W-1:0]            status_value,
  output logic                                   exec_valid
);
  import core_pkg::*;

  localparam int PC_W = $clog2(PROG_DEPTH);
  localparam logic [DATA_W:0] ADDR_LIMIT = 9'(ADDR_EXT_BASE) + 9'(DATA_DEPTH);

  logic [PC_W-1:0]    pc;
  logic [INSTR_W-1:0] ir;
  logic               ir_valid;
  logic [DATA_W-1:0]  w;
  logic [DATA_W-1:0]  status;
  logic [DATA_W-1:0]  fsr;

  alu_in_s            alu_in;
  alu_out_s           alu_out;
  logic [DATA_W-1:0]  eff_addr;
  logic [DATA_W-1:0]  file_val;
  logic [DATA_W-1:0]  bit_mask;
  logic               to_file;
  logic               to_w;
  logic               upd_c;
  logic               upd_nibble;
  logic               upd_z;
  logic               skip;
  logic               jump;
  logic               file_ext;
  logic [PC_W-1:0]    next_pc;
  logic               next_flush;

  core_alu u_alu (
    .alu_in  (alu_in),
    .alu_out (alu_out)
  );

  assign eff_addr = (ir[FILE_W-1:0] == '0) ? fsr : {3'b000, ir[FILE_W-1:0]};
  assign file_ext = (eff_addr >= ADDR_EXT_BASE) && ({1'b0, eff_addr} < ADDR_LIMIT);
  assign bit_mask = 8'h01 << ir[7:5];

  always_comb
  begin
    file_val = 8'h00;
    if (eff_addr == ADDR_PC)
      file_val = DATA_W'(pc);
    else if (eff_addr == ADDR_STATUS)
      file_val = status;
    else if (eff_addr == ADDR_FSR)
      file_val = fsr;
    else if (file_ext)
      file_val = data_rdata;
  end

  // Instruction decode; the indirect cell itself reads as zero, which stops self-reference loops.
  always_comb
  begin
    alu_in.op  = ALU_PASS_A;
    alu_in.a   = w;
    alu_in.b   = file_val;
    alu_in.cin = status[STATUS_C];
    to_file    = 1'b0;
    to_w       = 1'b0;
    upd_c      = 1'b0;
    upd_nibble = 1'b0;
    upd_z      = 1'b0;
    skip       = 1'b0;
    jump       = 1'b0;
    if (ir_valid)
    begin
      unique case (ir[11:10])
        2'b00:
        begin
          to_file = ir[5];
          to_w    = !ir[5];
          upd_z   = 1'b1;
          unique case (ir[9:6])
            4'h0:
            begin
              to_w  = 1'b0;
              upd_z = 1'b0;
            end
            4'h1: alu_in.op = ALU_CLR;
            4'h2:
            begin
              alu_in.op  = ALU_SUB;
              upd_c      = 1'b1;
              upd_nibble = 1'b1;
            end
            4'h3: alu_in.op = ALU_DEC;
            4'h4: alu_in.op = ALU_OR;
            4'h5: alu_in.op = ALU_AND;
            4'h6: alu_in.op = ALU_XOR;
            4'h7:
            begin
              alu_in.op  = ALU_ADD;
              upd_c      = 1'b1;
              upd_nibble = 1'b1;
            end
            4'h8: alu_in.op = ALU_PASS_B;
            4'h9: alu_in.op = ALU_COM;
            4'hA: alu_in.op = ALU_INC;
            4'hB:
            begin
              alu_in.op = ALU_DEC;
              upd_z     = 1'b0;
              skip      = (alu_out.res == '0);
            end
            4'hC:
            begin
              alu_in.op = ALU_RRF;
              upd_c     = 1'b1;
              upd_z     = 1'b0;
            end
            4'hD:
            begin
              alu_in.op = ALU_RLF;
              upd_c     = 1'b1;
              upd_z     = 1'b0;
            end
            4'hE:
            begin
              alu_in.op = ALU_SWAP;
              upd_z     = 1'b0;
            end
            4'hF:
            begin
              alu_in.op = ALU_INC;
              upd_z     = 1'b0;
              skip      = (alu_out.res == '0);
            end
          endcase
          if (ir[9:6] == 4'h1 && !ir[5])
            alu_in.op = ALU_CLR;
        end
        2'b01:
        begin
          alu_in.a = ir[8] ? bit_mask : ~bit_mask;
          unique case (ir[9:8])
            2'b00:
            begin
              alu_in.op = ALU_AND;
              to_file   = 1'b1;
            end
            2'b01:
            begin
              alu_in.op = ALU_OR;
              to_file   = 1'b1;
            end
            2'b10: skip = ((file_val & bit_mask) == '0);
            2'b11: skip = ((file_val & bit_mask) != '0);
          endcase
        end
        2'b10: jump = ir[9];
        2'b11:
        begin
          alu_in.a = ir[7:0];
          alu_in.b = ir[7:0];
          to_w     = 1'b1;
          upd_z    = (ir[9:8] != 2'b00);
          unique case (ir[9:8])
            2'b00: alu_in.op = ALU_PASS_A;
            2'b01: alu_in.op = ALU_OR;
            2'b10: alu_in.op = ALU_AND;
            2'b11: alu_in.op = ALU_XOR;
          endcase
          alu_in.b = w;
        end
      endcase
    end
  end

  assign data_addr  = eff_addr;
  assign data_wdata = alu_out.res;
  assign data_we    = to_file && file_ext;

  always_comb
  begin
    next_pc    = pc + 1'b1;
    next_flush = 1'b0;
    if (jump)
    begin
      next_pc    = PC_W'(ir[8:0]);
      next_flush = 1'b1;
    end
    else if (to_file && eff_addr == ADDR_PC)
    begin
      next_pc    = PC_W'(alu_out.res);
      next_flush = 1'b1;
    end
    else if (skip)
      next_flush = 1'b1;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pc       <= '0;
      ir       <= IR_RESET;
      ir_valid <= 1'b0;
    end
    else
    begin
      pc       <= next_pc;
      ir       <= prog_data;
      ir_valid <= !next_flush;
    end
  end
  assign prog_addr = pc;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      w <= W_RESET;
    else if (to_w)
      w <= alu_out.res;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      fsr <= FSR_RESET;
    else if (to_file && eff_addr == ADDR_FSR)
      fsr <= alu_out.res;
  end

  // flag update wins over file write
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      status <= STATUS_RESET;
    else
    begin
      if (to_file && eff_addr == ADDR_STATUS)
        status <= alu_out.res;
      if (upd_c)
        status[STATUS_C] <= alu_out.c;
      if (upd_nibble)
        status[STATUS_NIBBLE] <= alu_out.nibble_carry_flag;
      if (upd_z)
        status[STATUS_Z] <= alu_out.z;
    end
  end

  assign exec_valid   = ir_valid;
  assign acc_value    = w;
  assign status_value = status;
endmodule
`default_nettype wire

// ### tb/core_asserts.sv
// Concurrent checks on the ports of the core datapath.
`timescale 1ns/1ps
`default_nettype none
module core_asserts #(
  parameter int PROG_DEPTH = 1024,
  parameter int DATA_DEPTH = 72
) (
  input wire logic                          sys_clk,
  input wire logic                          sys_rst,
  input wire logic [$clog2(PROG_DEPTH)-1:0] prog_addr,
  input wire logic [core_pkg::INSTR_W-1:0]  prog_data,
  input wire logic [core_pkg::DATA_W-1:0]   data_addr,
  input wire logic [core_pkg::DATA_W-1:0]   data_wdata,
  input wire logic                          data_we,
  input wire logic [core_pkg::DATA_W-1:0]   data_rdata,
  input wire logic [core_pkg::DATA_W-1:0]   acc_value,
  input wire logic [core_pkg::DATA_W-1:0]   status_value,
  input wire logic                          exec_valid
);
  import core_pkg::*;
  localparam int PW = $clog2(PROG_DEPTH);
  logic [INSTR_W-1:0] ir;
  logic [8:0]         sum;
  logic [4:0]         nib;
  logic [8:0]         diff;
  logic [2:0]         add_flags;
  logic [2:0]         sub_flags;
  logic [PW-1:0]      jump_tgt;
  logic [7:0]         lit;
  logic               in_file;
  // Shadow of the instruction register, so the executing word is known.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ir <= IR_RESET;
    else
      ir <= prog_data;
  end
  assign sum       = {1'b0, acc_value} + {1'b0, data_rdata};
  assign nib       = {1'b0, acc_value[3:0]} + {1'b0, data_rdata[3:0]};
  assign diff      = {1'b0, data_rdata} - {1'b0, acc_value};
  assign add_flags = {sum[7:0] == 8'h00, nib[4], sum[8]};
  assign sub_flags = {diff[7:0] == 8'h00, data_rdata[3:0] >= acc_value[3:0], !diff[8]};
  assign jump_tgt  = PW'(ir[8:0]);
  assign lit       = ir[7:0];
  assign in_file   = (int'(data_addr) >= int'(ADDR_EXT_BASE)) && (int'(data_addr) < int'(ADDR_EXT_BASE) + DATA_DEPTH);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  jump_target_a : // jump target
    assert property (exec_valid && ir[11:9] == 3'b101 |=> !exec_valid && prog_addr == $past(jump_tgt))
      else $error("jump did not load target");
  refill_once_a : // single refill
    assert property (exec_valid && ir[11:9] == 3'b101 |-> ##1 !exec_valid ##1 exec_valid)
      else $error("refill after jump not one cycle");
  seq_fetch_a : // overlapped fetch
    assert property (exec_valid && ir[11:10] == 2'b11 |=> exec_valid && prog_addr == $past(prog_addr) + 1'b1)
      else $error("fetch did not advance");
  literal_load_a : // literal operand
    assert property (exec_valid && ir[11:8] == 4'hC |=> acc_value == $past(lit))
      else $error("literal not loaded");
  add_to_acc_a : // addition result
    assert property (exec_valid && ir[11:5] == 7'b0001110 && in_file |=> acc_value == $past(sum[7:0]))
      else $error("sum wrong");
  add_flags_a : // addition flags
    assert property (exec_valid && ir[11:6] == 6'b000111 && in_file |=> status_value[2:0] == $past(add_flags))
      else $error("add flags wrong");
  sub_flags_a : // borrow flags
    assert property (exec_valid && ir[11:6] == 6'b000010 && in_file |=> status_value[2:0] == $past(sub_flags))
      else $error("sub flags wrong");
  sub_to_acc_a : // difference result
    assert property (exec_valid && ir[11:5] == 7'b0000100 && in_file |=> acc_value == $past(diff[7:0]))
      else $error("difference wrong");
  we_range_a : // file bounds
    assert property (data_we |-> in_file && exec_valid)
      else $error("write outside file");
  single_cycle_a : // one-cycle ops
    assert property (exec_valid && ir[11:10] == 2'b00 && ir[9:6] != 4'hB && ir[9:6] != 4'hF
                     && !(ir[5] && data_addr == ADDR_PC) |=> exec_valid && prog_addr == $past(prog_addr) + 1'b1)
      else $error("byte op did not finish in one cycle");
endmodule
`default_nettype wire

// ### tb/core_mem_model.sv
// Behavioural program memory and data file on the far side of the core.
`timescale 1ns/1ps
`default_nettype none
module core_mem_model #(
  parameter int PROG_DEPTH = 1024
) (
  input  wire logic                          sys_clk,
  input  wire logic [$clog2(PROG_DEPTH)-1:0] prog_addr,
  output logic [core_pkg::INSTR_W-1:0]       prog_data,
  input  wire logic [core_pkg::DATA_W-1:0]   data_addr,
  input  wire logic [core_pkg::DATA_W-1:0]   data_wdata,
  input  wire logic                          data_we,
  output logic [core_pkg::DATA_W-1:0]        data_rdata
);
  import core_pkg::*;
  logic [INSTR_W-1:0] rom [PROG_DEPTH];
  logic [DATA_W-1:0]  ram [256];
  assign prog_data = rom[prog_addr];
  assign data_rdata = ram[data_addr];
  // Plain always, since the bench also presets the array.
  always @(posedge sys_clk)
  begin
    if (data_we)
      ram[data_addr] <= data_wdata;
  end
endmodule
`default_nettype wire

// ### tb/tb_eight_bit_risc_core_datapath.sv
// Self-checking bench for the core datapath.
`timescale 1ns/1ps
`default_nettype none
module tb_eight_bit_risc_core_datapath;
  import core_pkg::*;
  localparam int PROG_DEPTH = 1024;
  localparam int DATA_DEPTH = 72;
  localparam int LIMIT      = 2000;
  logic                          sys_clk;
  logic                          sys_rst;
  logic [$clog2(PROG_DEPTH)-1:0] prog_addr;
  logic [INSTR_W-1:0]            prog_data;
  logic [DATA_W-1:0]             data_addr;
  logic [DATA_W-1:0]             data_wdata;
  logic                          data_we;
  logic [DATA_W-1:0]             data_rdata;
  logic [DATA_W-1:0]             acc_value;
  logic [DATA_W-1:0]             status_value;
  logic                          exec_valid;
  int                            errors;
  int                            tests_run;
  int                            cycles;
  eight_bit_risc_core_datapath #(.PROG_DEPTH(PROG_DEPTH), .DATA_DEPTH(DATA_DEPTH)) eight_bit_risc_core_datapath_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
    .data_wdata(data_wdata), .data_we(data_we), .data_rdata(data_rdata), .acc_value(acc_value),
    .status_value(status_value), .exec_valid(exec_valid));
  core_mem_model #(.PROG_DEPTH(PROG_DEPTH)) core_mem_model_i (
    .sys_clk(sys_clk), .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
    .data_wdata(data_wdata), .data_we(data_we), .data_rdata(data_rdata));
  always #50 sys_clk = ~sys_clk;
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // A hang counts as a mismatch and still reaches the report.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Loads a program under reset, then lets it run into its closing loop.
  task automatic run(input logic [11:0] w [8]);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    // The program is swapped only while the core sits in reset, so no edge latches a half-loaded word.
    for (int i = 0; i < PROG_DEPTH; i++)
      core_mem_model_i.rom[i] <= (i < 8) ? w[i] : 12'h000;
    sys_rst <= 1'b0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic t_add;
    run('{12'hC0F, 12'h030, 12'hC01, 12'h1D0, 12'hA04, 12'h000, 12'h000, 12'h000});
    check(acc_value, 8'h10);
    check(status_value, 8'h02);
    check(core_mem_model_i.ram[16], 8'h0F);
  endtask
  task automatic t_sub;
    run('{12'hC0F, 12'h030, 12'hC10, 12'h090, 12'hA04, 12'h000, 12'h000, 12'h000});
    check(acc_value, 8'hFF);
    check(status_value, 8'h02);
    run('{12'hC0F, 12'h030, 12'hC0F, 12'h090, 12'hA04, 12'h000, 12'h000, 12'h000});
    check(status_value, 8'h07);
  endtask
  task automatic t_jump;
    run('{12'hA05, 12'hC33, 12'h000, 12'h000, 12'h000, 12'hD5A, 12'hA06, 12'h000});
    check(acc_value, 8'h5A);
  endtask
  task automatic t_pc_write;
    run('{12'hC06, 12'h022, 12'hC11, 12'hA03, 12'h000, 12'h000, 12'hC77, 12'hA07});
    check(acc_value, 8'h77);
  endtask
  task automatic t_indirect;
    run('{12'hC20, 12'h024, 12'hC3C, 12'h020, 12'hC00, 12'h200, 12'h503, 12'hA07});
    check(core_mem_model_i.ram[32], 8'h3C);
    check(acc_value, 8'h3C);
    check(status_value, 8'h01);
  endtask
  task automatic t_skip;
    run('{12'hC3C, 12'h030, 12'h390, 12'h2F0, 12'h6D0, 12'hF55, 12'hF0F, 12'hA07});
    check(acc_value, 8'hCC);
    check(core_mem_model_i.ram[16], 8'h3B);
  endtask
  task automatic t_reset;
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(negedge sys_clk);
    check(acc_value, W_RESET);
    check(status_value, STATUS_RESET);
    check({7'h00, exec_valid}, 8'h00);
    check(prog_addr[7:0], 8'h00);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    errors = 0;
    tests_run = 0;
    cycles = 0;
    for (int i = 0; i < 256; i++)
      core_mem_model_i.ram[i] = 8'h00;
    repeat (2) @(posedge sys_clk);
    t_add();
    t_sub();
    t_jump();
    t_pc_write();
    t_indirect();
    t_skip();
    t_reset();
    tally_and_finish();
  end
endmodule
bind eight_bit_risc_core_datapath core_asserts #(.PROG_DEPTH(PROG_DEPTH), .DATA_DEPTH(DATA_DEPTH)) core_asserts_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
  .data_wdata(data_wdata), .data_we(data_we), .data_rdata(data_rdata), .acc_value(acc_value),
  .status_value(status_value), .exec_valid(exec_valid));
`default_nettype wire
